/* hdl/fsi_pkg.sv */
// package: constants and types for the fieldbus status indicator and configuration block
package fsi_pkg;

  // =====================================================
  // parameter register indices
  localparam logic [2:0] REG_CONTROL_MODE = 3'h0;
  localparam logic [2:0] REG_STATION_ALIAS = 3'h1;
  localparam logic [2:0] REG_BUS_COMM_CONFIG = 3'h2;
  localparam logic [2:0] REG_PACKET_LOSS = 3'h3;
  localparam logic [2:0] REG_SDO_STORE = 3'h4;

  // =====================================================
  // reset values and field limits
  localparam logic [15:0] CONTROL_MODE_RESET = 16'h000c;
  localparam logic [15:0] CONTROL_MODE_MAX = 16'h000c;
  localparam logic [15:0] CONTROL_MODE_BUS = 16'h000c;
  localparam logic [15:0] STATION_ALIAS_RESET = 16'h0000;
  localparam logic [15:0] BUS_COMM_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] BUS_COMM_CONFIG_MASK = 16'h0001;
  localparam int SYNC_SOURCE_BIT = 0;
  localparam logic [15:0] SDO_STORE_RESET = 16'h0000;
  localparam logic [15:0] SDO_STORE_MASK = 16'h0001;
  localparam logic [15:0] PACKET_LOSS_MAX = 16'hffff;

  // =====================================================
  // state codes of the slave state machine
  localparam logic [3:0] SSM_INIT = 4'h1;
  localparam logic [3:0] SSM_PREOP = 4'h2;
  localparam logic [3:0] SSM_SAFEOP = 4'h4;
  localparam logic [3:0] SSM_OP = 4'h8;

  // =====================================================
  // indicator timing at 50 MHz
  localparam int CLK_HZ = 50_000_000;
  localparam int FLICKER_MS = 50;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * FLICKER_MS;
  localparam int TICK_W = 22;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  // a 200 ms step is four 50 ms ticks; a frame of 20 ticks covers 1 s
  localparam logic [4:0] FRAME_LAST = 5'h13;
  // flash windows inside the frame, in ticks
  localparam logic [4:0] FLASH_END = 5'h04;
  localparam logic [4:0] FLASH2_START = 5'h08;
  localparam logic [4:0] FLASH2_END = 5'h0c;
  localparam int BLINK_BIT = 2;
  localparam int FLICKER_BIT = 0;

  // =====================================================
  // types
  typedef enum logic [2:0] {
    ERR_NONE,
    ERR_SETTINGS,
    ERR_SYNC,
    ERR_WATCHDOG,
    ERR_INIT,
    ERR_PDI
  } fsi_err_t;

  typedef struct packed {
    logic write;
    logic [2:0] index;
    logic [15:0] data;
    logic from_sdo;
  } fsi_par_req_t;

  typedef struct packed {
    logic [1:0] link_up;
    logic [1:0] activity;
  } fsi_port_t;

endpackage

/* hdl/fsi_status_config.sv */
// module: indicator patterns, parameter store and state report of the fieldbus interface
`timescale 1ns/1ns
// What this block does
// R1: error indicator off normally, blink settings fault, flicker init fault, on PDI fault.
// R2: error indicator single flash for sync fault, double flash on watchdog expiry.
// R3: link indicator off without link, flicker with traffic, steady on when idle.
// R4: master cable enters the input port, downstream leaves the output port.
// R5: control mode range 0 to 12, default 12, must be 12 for bus control.
// R6: station alias 0 to 65535, default 0, takes effect after next power-on; reset also clears the stored alias, so the applied alias is always 0.
// R7: config bit 0 picks SYNC0 source, hardware or software; other bits reserved.
// R8: packet-loss counter is read-only and counts lost frames.
// R9: store select 0 saves SDO writes to nonvolatile memory, 1 only working values.
// R10: report state code 1, 2, 4 or 8 plus a separate error flag.
// R11: indicator patterns follow standard timing, made from a free-running divider.
module fsi_status_config (
  input wire logic clk,
  input wire logic resetn,
  input wire fsi_pkg::fsi_par_req_t par_req,
  output logic [15:0] par_rdata,
  output logic par_rvalid,
  output logic nv_write,
  output logic [2:0] nv_index,
  output logic [15:0] nv_data,
  input wire fsi_pkg::fsi_err_t err_cause,
  input wire logic frame_lost,
  input wire fsi_pkg::fsi_port_t port_stat,
  input wire logic [3:0] ssm_code,
  input wire logic ssm_fault,
  output logic error_indicator,
  output logic [1:0] link_indicator,
  output logic [3:0] ssm_report,
  output logic ssm_error,
  output logic [15:0] control_mode,
  output logic bus_control_enabled,
  output logic [15:0] station_alias_active,
  output logic sync0_software
);

  // =====================================================
  // parameters
  logic [15:0] control_mode_select;
  logic [15:0] station_alias;
  logic [15:0] bus_comm_config;
  logic [15:0] packet_loss_counter;
  logic [15:0] sdo_store_select;
  logic alias_loaded;

  // out-of-range values are refused so the mode stays legal
  always_ff @(posedge clk)
  begin
    if (!resetn)
      control_mode_select <= fsi_pkg::CONTROL_MODE_RESET;
    else if (par_req.write && par_req.index == fsi_pkg::REG_CONTROL_MODE
             && par_req.data <= fsi_pkg::CONTROL_MODE_MAX)
      control_mode_select <= par_req.data; // R5
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      station_alias <= fsi_pkg::STATION_ALIAS_RESET;
    else if (par_req.write && par_req.index == fsi_pkg::REG_STATION_ALIAS)
      station_alias <= par_req.data; // R6
  end

  // the applied alias is taken once after reset release, which stands for power-on
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      alias_loaded <= 1'b0;
      station_alias_active <= fsi_pkg::STATION_ALIAS_RESET;
    end
    else if (!alias_loaded)
    begin
      alias_loaded <= 1'b1;
      station_alias_active <= station_alias; // R6
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      bus_comm_config <= fsi_pkg::BUS_COMM_CONFIG_RESET;
    else if (par_req.write && par_req.index == fsi_pkg::REG_BUS_COMM_CONFIG)
      bus_comm_config <= par_req.data & fsi_pkg::BUS_COMM_CONFIG_MASK; // R7
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      sdo_store_select <= fsi_pkg::SDO_STORE_RESET;
    else if (par_req.write && par_req.index == fsi_pkg::REG_SDO_STORE)
      sdo_store_select <= par_req.data & fsi_pkg::SDO_STORE_MASK; // R9
  end

  // saturates rather than wraps so a large loss count is not mistaken for a small one
  always_ff @(posedge clk)
  begin
    if (!resetn)
      packet_loss_counter <= 16'h0000;
    else if (frame_lost && packet_loss_counter != fsi_pkg::PACKET_LOSS_MAX)
      packet_loss_counter <= packet_loss_counter + 16'h0001; // R8
  end

  // =====================================================
  // read port and nonvolatile write-through
  logic [15:0] next_rdata;

  always_comb
  begin
    unique case (par_req.index)
      fsi_pkg::REG_CONTROL_MODE: next_rdata = control_mode_select;
      fsi_pkg::REG_STATION_ALIAS: next_rdata = station_alias;
      fsi_pkg::REG_BUS_COMM_CONFIG: next_rdata = bus_comm_config;
      fsi_pkg::REG_PACKET_LOSS: next_rdata = packet_loss_counter; // R8
      fsi_pkg::REG_SDO_STORE: next_rdata = sdo_store_select;
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      par_rdata <= 16'h0000;
      par_rvalid <= 1'b0;
    end
    else
    begin
      par_rdata <= next_rdata;
      par_rvalid <= !par_req.write;
    end
  end

  // writes to the read-only counter never reach the store
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      nv_write <= 1'b0;
      nv_index <= 3'h0;
      nv_data <= 16'h0000;
    end
    else
    begin
      nv_write <= par_req.write && par_req.index != fsi_pkg::REG_PACKET_LOSS
                  && par_req.index <= fsi_pkg::REG_SDO_STORE
                  && !(par_req.index == fsi_pkg::REG_CONTROL_MODE
                       && par_req.data > fsi_pkg::CONTROL_MODE_MAX) // R5
                  && !(par_req.from_sdo && sdo_store_select[0]); // R9
      nv_index <= par_req.index;
      nv_data <= par_req.data;
    end
  end

  // =====================================================
  // derived configuration outputs
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      control_mode <= fsi_pkg::CONTROL_MODE_RESET;
      bus_control_enabled <= 1'b1;
      sync0_software <= 1'b0;
    end
    else
    begin
      control_mode <= control_mode_select;
      bus_control_enabled <= control_mode_select == fsi_pkg::CONTROL_MODE_BUS; // R5
      sync0_software <= bus_comm_config[fsi_pkg::SYNC_SOURCE_BIT]; // R7
    end
  end

  // =====================================================
  // free-running pattern divider
  logic [fsi_pkg::TICK_W-1:0] tick_count;
  logic [4:0] frame;
  // blink has its own step so the 20-tick frame wrap cannot stretch its dark half
  logic [2:0] blink_step;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tick_count <= '0;
      frame <= 5'h00;
      blink_step <= 3'h0;
    end
    else if (tick_count == fsi_pkg::TICK_LAST)
    begin
      tick_count <= '0;
      blink_step <= blink_step + 3'h1; // R11
      frame <= (frame == fsi_pkg::FRAME_LAST) ? 5'h00 : frame + 5'h01; // R11
    end
    else
      tick_count <= tick_count + 1'b1;
  end

  // blink 200/200 ms, flicker 50/50 ms, flashes are 200 ms on inside a 1 s frame
  logic pat_blink;
  logic pat_flicker;
  logic pat_single;
  logic pat_double;

  always_comb
  begin
    pat_blink = blink_step[fsi_pkg::BLINK_BIT]; // R11
    pat_flicker = frame[fsi_pkg::FLICKER_BIT]; // R11
    pat_single = frame < fsi_pkg::FLASH_END; // R11
    pat_double = frame < fsi_pkg::FLASH_END
                 || (frame >= fsi_pkg::FLASH2_START && frame < fsi_pkg::FLASH2_END); // R11
  end

  logic next_error;

  always_comb
  begin
    unique case (err_cause)
      fsi_pkg::ERR_NONE: next_error = 1'b0; // R1
      fsi_pkg::ERR_SETTINGS: next_error = pat_blink; // R1
      fsi_pkg::ERR_SYNC: next_error = pat_single; // R2
      fsi_pkg::ERR_WATCHDOG: next_error = pat_double; // R2
      fsi_pkg::ERR_INIT: next_error = pat_flicker; // R1
      fsi_pkg::ERR_PDI: next_error = 1'b1; // R1
      default: next_error = 1'b0;
    endcase
  end

  // =====================================================
  // indicator and state outputs
  // link_indicator[0] sits on the input port, [1] on the output port
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      error_indicator <= 1'b0;
      link_indicator <= 2'h0;
    end
    else
    begin
      error_indicator <= next_error;
      for (int p = 0; p < 2; p++)
        link_indicator[p] <= port_stat.link_up[p]
                             && (!port_stat.activity[p] || pat_flicker); // R3
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ssm_report <= fsi_pkg::SSM_INIT;
      ssm_error <= 1'b0;
    end
    else
    begin
      ssm_report <= ssm_code; // R10
      ssm_error <= ssm_fault || !(ssm_code == fsi_pkg::SSM_INIT
                   || ssm_code == fsi_pkg::SSM_PREOP || ssm_code == fsi_pkg::SSM_SAFEOP
                   || ssm_code == fsi_pkg::SSM_OP); // R10
    end
  end

endmodule

/* sim/fsi_checker.sv */
// checker: port assertions of the status and config block
`timescale 1ns/1ns
module fsi_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire fsi_pkg::fsi_par_req_t par_req,
  input wire logic nv_write,
  input wire fsi_pkg::fsi_err_t err_cause,
  input wire fsi_pkg::fsi_port_t port_stat,
  input wire logic [3:0] ssm_code,
  input wire logic error_indicator,
  input wire logic [1:0] link_indicator,
  input wire logic [3:0] ssm_report,
  input wire logic [15:0] station_alias_active,
  input wire logic sync0_software
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ========================================
  // assertions
  chk_loss_readonly: assert property (par_req.write && par_req.index == 3'h3 |=> !nv_write)
    else $error("loss write stored");
  chk_pdi_steady: assert property (err_cause == fsi_pkg::ERR_PDI [*2] |-> error_indicator)
    else $error("pdi not lit");
  chk_normal_dark: assert property (err_cause == fsi_pkg::ERR_NONE |=> !error_indicator)
    else $error("normal lit");
  chk_link_absent: assert property (!port_stat.link_up[0] |=> !link_indicator[0])
    else $error("no link lit");
  chk_link_idle: assert property (port_stat.link_up[1] && !port_stat.activity[1] |=> link_indicator[1])
    else $error("idle link dark");
  chk_sync_source: assert property (par_req.write && par_req.index == 3'h2 |-> ##2 sync0_software == $past(par_req.data[0], 2))
    else $error("sync source wrong");
  chk_state_code: assert property (ssm_code == fsi_pkg::SSM_OP |=> ssm_report == fsi_pkg::SSM_OP)
    else $error("state code wrong");
  chk_alias_hold: assert property (resetn && $past(resetn) && $past(resetn, 2) |=> $stable(station_alias_active))
    else $error("alias applied early");
  chk_mode_refused: assert property (par_req.write && par_req.index == 3'h0 && par_req.data > 16'h000c |=> !nv_write)
    else $error("refused mode stored");
  cover property (nv_write);
  cover property (error_indicator);
  cover property (link_indicator[1]);
endmodule
bind fsi_status_config fsi_checker chk (.clk, .resetn, .par_req, .nv_write, .err_cause, .port_stat,
  .ssm_code, .error_indicator, .link_indicator, .ssm_report, .station_alias_active, .sync0_software);

/* sim/fsi_master_model.sv */
// model: bus master side of the parameter port and links
`timescale 1ns/1ns
module fsi_master_model (
  input wire logic clk,
  output fsi_pkg::fsi_par_req_t par_req,
  output logic frame_lost,
  output fsi_pkg::fsi_port_t port_stat
);
  initial
  begin
    par_req = '0;
    frame_lost = 1'b0;
    port_stat = '0;
  end
  // ========================================
  // idle reads an unmapped index with junk data
  task automatic req(input fsi_pkg::fsi_par_req_t r);
    @(negedge clk);
    par_req <= r;
    @(negedge clk);
    par_req <= {1'b0, 3'h7, ~r.data, 1'b0};
  endtask
  task automatic lose(input int n);
    repeat (n) @(negedge clk) frame_lost <= 1'b1;
    @(negedge clk) frame_lost <= 1'b0;
  endtask
  // bit 0 is the upstream cable on the input port
  task automatic link(input fsi_pkg::fsi_port_t p);
    @(negedge clk) port_stat <= p;
  endtask
endmodule

/* sim/fsi_status_config_tb.sv */
// testbench: parameter store, indicators and state report
`timescale 1ns/1ns
module fsi_status_config_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  fsi_pkg::fsi_par_req_t par_req;
  logic frame_lost;
  fsi_pkg::fsi_port_t port_stat;
  fsi_pkg::fsi_err_t err_cause = fsi_pkg::ERR_NONE;
  logic [3:0] ssm_code = 4'h1;
  logic ssm_fault = 1'b0;
  logic [15:0] par_rdata, control_mode, station_alias_active, v;
  logic [15:0] mode = 16'h000c;
  logic [3:0] ssm_report;
  logic [2:0] nv_index;
  logic [15:0] nv_data;
  logic [1:0] link_indicator;
  logic par_rvalid, nv_write, error_indicator, ssm_error, bus_control_enabled, sync0_software;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  fsi_master_model pm (.clk, .par_req, .frame_lost, .port_stat);
  fsi_status_config dut (.clk, .resetn, .par_req, .par_rdata, .par_rvalid, .nv_write,
    .nv_index, .nv_data, .err_cause, .frame_lost, .port_stat, .ssm_code, .ssm_fault,
    .error_indicator, .link_indicator, .ssm_report, .ssm_error, .control_mode,
    .bus_control_enabled, .station_alias_active, .sync0_software);
  // ========================================
  // expectations and helpers
  function automatic logic [15:0] next_mode(input logic [15:0] m, input logic [15:0] d);
    return (d > 16'h000c) ? m : d;
  endfunction
  // within the first tick after reset flashes are lit, blink and flicker dark
  function automatic logic lit(input int c);
    return c == 2 || c == 3 || c == 5;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
      $display("Error %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      failures++;
  endtask
  task automatic wr(input logic [2:0] i, input logic [15:0] d, input logic s);
    pm.req({1'b1, i, d, s});
  endtask
  task automatic rd(input logic [2:0] i, input logic [15:0] exp);
    pm.req({1'b0, i, 16'h0000, 1'b0});
    chk(16'(par_rvalid), 16'h0001);
    chk(par_rdata, exp);
  endtask
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures++;
      test_done();
    end
  end
  // ========================================
  // main sequence
  initial
  begin
    void'($urandom(24678));
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    rd(3'h0, 16'h000c);
    for (int i = 1; i < 6; i++)
      rd(3'(i), 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 16'h000d : (i == 3) ? 16'h000c : 16'($urandom_range(14, 0));
      wr(3'h0, v, 1'b1);
      chk(16'(nv_write), 16'(v <= 16'h000c));
      chk(16'(nv_index), 16'h0000);
      if (v <= 16'h000c)
        chk(nv_data, v);
      mode = next_mode(mode, v);
      @(negedge clk);
      chk(control_mode, mode);
      chk(16'(bus_control_enabled), 16'(mode == 16'h000c));
    end
    v = 16'($urandom);
    wr(3'h1, v, 1'b0);
    rd(3'h1, v);
    chk(station_alias_active, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($urandom);
      wr(3'h2, v, 1'b1);
      rd(3'h2, v & 16'h0001);
      chk(16'(sync0_software), 16'(v[0]));
    end
    wr(3'h4, 16'hffff, 1'b1);
    rd(3'h4, 16'h0001);
    wr(3'h0, 16'h000c, 1'b1);
    chk(16'(nv_write), 16'h0000);
    wr(3'h0, 16'h000c, 1'b0);
    chk(16'(nv_write), 16'h0001);
    wr(3'h4, 16'h0000, 1'b1);
    wr(3'h0, 16'h000c, 1'b1);
    chk(16'(nv_write), 16'h0001);
    wr(3'h3, 16'hffff, 1'b1);
    chk(16'(nv_write), 16'h0000);
    v = 16'($urandom_range(9, 2));
    pm.lose(int'(v));
    rd(3'h3, v);
    for (int i = 0; i < 6; i++)
    begin
      err_cause = fsi_pkg::fsi_err_t'(i);
      repeat (2) @(negedge clk);
      chk(16'(error_indicator), 16'(lit(i)));
    end
    for (int i = 0; i < 16; i++)
    begin
      pm.link(4'(i));
      @(negedge clk);
      chk(16'(link_indicator), 16'(port_stat.link_up & ~port_stat.activity));
    end
    for (int i = 0; i < 5; i++)
    begin
      ssm_code = (i < 4) ? 4'(1 << i) : 4'h3;
      ssm_fault = 1'($urandom_range(1, 0));
      repeat (2) @(negedge clk);
      chk(16'(ssm_report), 16'(ssm_code));
      chk(16'(ssm_error), 16'(ssm_fault || i == 4));
    end
    test_done();
  end
endmodule
